// ---- ais_regs.svh ----
`ifndef AIS_REGS_SVH
`define AIS_REGS_SVH
// Register offsets (byte addresses)
`define AIS_INPUT_SELECT_OFS 12'h000
`define AIS_STATUS_OFS 12'h004
// Field positions
`define AIS_B_NEG_BIT 31
`define AIS_B_POS_HI 27
`define AIS_B_POS_LO 24
`define AIS_A_NEG_BIT 23
`define AIS_A_POS_HI 19
`define AIS_A_POS_LO 16
// Reset values
`define AIS_INPUT_SELECT_RST 32'h00000000
// Implemented bits of the select register
`define AIS_INPUT_SELECT_MASK 32'h8f8f0000
// Positive select codes
`define AIS_POS_LAST_PIN 4'hc
`define AIS_POS_TEMP 4'hd
`define AIS_POS_INTERNAL_VOLTAGE_REFERENCE 4'he
`define AIS_POS_OPEN 4'hf
`endif

// ---- ais_pkg.sv ----
package ais_pkg;
  // One sample setting: negative bit and positive code
  typedef struct packed {
    logic neg_sel;
    logic [3:0] pos_sel;
  } ais_sample_s;

  // Decoded routing of one sample setting
  typedef struct packed {
    logic [12:0] pos_pin_onehot;
    logic pos_temp;
    logic pos_internal_voltage_reference;
    logic pos_open;
    logic neg_input_one;
    logic neg_low_ref;
  } ais_route_s;
endpackage

// ---- ais_route_dec.sv ----
`timescale 1ns/1ps
`include "ais_regs.svh"
module ais_route_dec
  import ais_pkg::*;
(
  // Selected setting
  input wire ais_sample_s sample,
  // Decoded routing
  output ais_route_s route
);

  // Positive and negative multiplexer decode
  always_comb
  begin
    route = '0;
    if (sample.pos_sel <= `AIS_POS_LAST_PIN)
      route.pos_pin_onehot = 13'h0001 << sample.pos_sel;
    route.pos_temp = (sample.pos_sel == `AIS_POS_TEMP);
    route.pos_internal_voltage_reference = (sample.pos_sel == `AIS_POS_INTERNAL_VOLTAGE_REFERENCE);
    route.pos_open = (sample.pos_sel == `AIS_POS_OPEN);
    route.neg_input_one = sample.neg_sel;
    route.neg_low_ref = ~sample.neg_sel;
  end

endmodule // ais_route_dec

// ---- ais_input_select.sv ----
// How it works
// - Sample B negative: input one or low ref
// - Sample B positive code picks pin/sensor/ref/open
// - Sample A negative: input one or low ref
// - Sample A positive uses same code map
// - Unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
`include "ais_regs.svh"
module ais_input_select
  import ais_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter sequencing: high selects sample B setting
  input wire logic sample_b_phase,
  // Raw settings
  output ais_sample_s sample_a_setting,
  output ais_sample_s sample_b_setting,
  // Routing of the active setting to the analog multiplexer
  output ais_route_s active_route
);

  logic [31:0] select_q;
  logic [31:0] select_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic phase_q;
  ais_sample_s active_sample;

  // Address is known to the map
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `AIS_INPUT_SELECT_OFS) || (a == `AIS_STATUS_OFS);
  endfunction

  wire access = psel & penable;
  wire wr_sel = access & pwrite & (paddr == `AIS_INPUT_SELECT_OFS);

  // Byte-lane merge, keep only implemented bits
  always_comb
  begin
    select_d = select_q;
    for (int i = 0; i < 4; i++)
      if (pstrb[i])
        select_d[i*8 +: 8] = pwdata[i*8 +: 8];
    select_d = select_d & `AIS_INPUT_SELECT_MASK;
  end

  // Select register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      select_q <= `AIS_INPUT_SELECT_RST;
    else if (wr_sel)
      select_q <= select_d;
  end

  // Read data and error answer
  always_comb
  begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (access)
    begin
      pslverr_d = ~addr_hit(paddr);
      if (pwrite && paddr == `AIS_STATUS_OFS)
        pslverr_d = 1'b1;
      prdata_d = 32'h00000000;
      if (!pwrite && paddr == `AIS_INPUT_SELECT_OFS)
        prdata_d = select_q & `AIS_INPUT_SELECT_MASK;
      else if (!pwrite && paddr == `AIS_STATUS_OFS)
        prdata_d = {31'h00000000, phase_q};
    end
  end

  // Registered read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else
      prdata_q <= prdata_d;
  end

  // Registered error flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_q <= 1'b0;
    else
      pslverr_q <= pslverr_d;
  end

  // Sample phase as seen by the multiplexer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_q <= 1'b0;
    else
      phase_q <= sample_b_phase;
  end

  // Zero-wait answer: read data appears with the access cycle
  assign pready = 1'b1;
  assign prdata = access ? prdata_d : prdata_q;
  assign pslverr = access ? pslverr_d : pslverr_q;

  // Field extraction
  assign sample_b_setting.neg_sel = select_q[`AIS_B_NEG_BIT];
  assign sample_b_setting.pos_sel =
    select_q[`AIS_B_POS_HI:`AIS_B_POS_LO];
  assign sample_a_setting.neg_sel = select_q[`AIS_A_NEG_BIT];
  assign sample_a_setting.pos_sel =
    select_q[`AIS_A_POS_HI:`AIS_A_POS_LO];

  // Pick the setting for the current sample
  assign active_sample = phase_q ? sample_b_setting : sample_a_setting;

  // Multiplexer decode; open code and missing pins trusted to software
  ais_route_dec u_dec (
    .sample(active_sample),
    .route(active_route)
  );

endmodule // ais_input_select

// ---- ais_input_select_properties.sv ----
`timescale 1ns/1ps
module ais_input_select_properties
  import ais_pkg::*;
(
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  // Converter sequencing
  input wire logic sample_b_phase,
  // Settings
  input wire ais_sample_s sample_a_setting,
  input wire ais_sample_s sample_b_setting,
  input wire ais_route_s active_route
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accesses to the select register
  wire ac = psel && penable && paddr == 12'h000;
  wire wb = ac && pwrite && pstrb[3];
  wire wa = ac && pwrite && pstrb[2];
  property p_wb;
    wb |=> sample_b_setting == $past({pwdata[31], pwdata[27:24]});
  endproperty
  a_wb: assert property (p_wb) else $error("b write");
  property p_wa;
    wa |=> sample_a_setting == $past({pwdata[23], pwdata[19:16]});
  endproperty
  a_wa: assert property (p_wa) else $error("a write");
  property p_rd; ac && !pwrite |-> (prdata & 32'h7070ffff) == '0; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_rs;
    $rose(presetn) |-> {sample_a_setting, sample_b_setting} == '0;
  endproperty
  a_rs: assert property (p_rs) else $error("reset");
  property p_ng;
    active_route.neg_input_one == ($past(sample_b_phase) ?
      sample_b_setting.neg_sel : sample_a_setting.neg_sel);
  endproperty
  a_ng: assert property (p_ng) else $error("neg");
  property p_op;
    active_route.pos_open == ($past(sample_b_phase) ?
      &sample_b_setting.pos_sel : &sample_a_setting.pos_sel);
  endproperty
  a_op: assert property (p_op) else $error("open");
  c_wb: cover property (wb);
  c_rd: cover property (ac && !pwrite);
  c_op: cover property (active_route.pos_open);
endmodule // ais_input_select_properties
bind ais_input_select ais_input_select_properties u_prop (.*);

// ---- ais_input_select_tb_top.sv ----
`timescale 1ns/1ps
module ais_input_select_tb_top;
  import ais_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic sample_b_phase = '0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = '0;
  ais_sample_s sample_a_setting, sample_b_setting;
  ais_route_s active_route;
  int bad_count = 0, n_checks = 0, cyc = 0;
  ais_input_select u_dut (.*);
  // Clock
  always #2.5 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk)
    if (++cyc == 3000)
    begin
      bad_count++;
      results();
    end
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Setup, then access until ready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
    logic [3:0] s, logic [31:0] e, logic er);
    @(posedge pclk);
    psel <= '1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= '1;
    do @(posedge pclk); while (pready !== '1);
    if (!w && !er)
      chk("prdata", prdata, e);
    chk("pslverr", pslverr, er);
    psel <= '0;
    penable <= '0;
  endtask
  // Expected routing of one setting
  function automatic logic [17:0] rt(logic n, logic [3:0] p);
    return {(p < 4'hd) ? 13'h1 << p : 13'h0,
      p == 4'hd, p == 4'he, p == 4'hf, n, !n};
  endfunction
  initial
  begin
    logic [3:0] k;
    repeat (4) @(posedge pclk);
    presetn <= '1;
    chk("route", active_route, 18'h00021);
    apb('0, '0, '0, '0, '0, '0);
    apb('1, '0, '1, 4'hf, '0, '0);
    apb('0, '0, '0, '0, 32'h8f8f0000, '0);
    apb('1, '0, '0, 4'h4, '0, '0);
    apb('1, 12'h008, '1, 4'hf, '0, '1);
    apb('1, 12'h004, '1, 4'hf, '0, '1);
    apb('0, '0, '0, '0, 32'h8f000000, '0);
    for (int c = 0; c < 32; c++)
    begin
      k = c[3:0];
      // Decode sweep, all codes on both samples
      apb('1, '0, {!k[0], 3'h0, k, k[0], 3'h0, ~k, 16'h0},
        4'hf, '0, '0);
      sample_b_phase <= c[4];
      repeat (2) @(posedge pclk);
      chk("route", active_route, c[4] ? rt(!k[0], k) : rt(k[0], ~k));
      apb('0, 12'h004, '0, '0, {31'h0, c[4]}, '0);
    end
    results();
  end
endmodule // ais_input_select_tb_top
